// ### core/clock_ctrl_pkg.sv
package clock_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Three-level pin codes.
   typedef logic [1:0] level_t;
   localparam level_t LVL_LOW = 2'h0;
   localparam level_t LVL_MID = 2'h1;
   localparam level_t LVL_HIGH = 2'h2;

   typedef struct packed {
      level_t bypass;
      level_t align;
      level_t vco;
      logic oe_n;
   } straps_t;

   // One bank select pair: upper digit then lower digit.
   typedef struct packed {
      level_t hi;
      level_t lo;
   } phase_sel_t;

   localparam int NUM_BANKS = 4;
   localparam int OUTS_PER_BANK = 2;
   localparam int STRAP_W = $bits(straps_t);
   localparam int PHASE_W = NUM_BANKS * $bits(phase_sel_t);

   ////////////////////////////////////////////////////////////////////////////////
   // Register map.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PHASE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_PHASE_STATUS = 8'h0c;

   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_STRAP_LSB = 1;
   localparam int CTRL_PHASE_OVR_BIT = 8;
   localparam logic [8:0] CTRL_RESET = 9'h000;
   localparam logic [15:0] PHASE_RESET = 16'h5555;

   localparam int STAT_PLL_EN_BIT = 7;
   localparam int STAT_LOCK_BIT = 8;
   localparam int STAT_DRIVE_BIT = 9;
   localparam int STAT_STOP_LSB = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // Skew and divider figures.
   localparam int MF_LOW = 32;
   localparam int MF_MID = 16;
   localparam int MF_HIGH = 8;
   localparam int NARROW_SKEW_MAX = 4;
   localparam int WIDE_SKEW_MULT = 2;
   localparam int WIDE_SKEW_MAX = 6;
   localparam int CODE_ZERO = 4;
   localparam int CODE_LL = 0;
   localparam int CODE_HH = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Lock detector timing.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int LOCK_WIN_NS = 40;
   localparam int LOCK_WIN_CYC = (LOCK_WIN_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_EDGES = 8;

endpackage

// ### core/multiphase_clock_output_control.sv
`timescale 1ns/100ps
// Functional notes
// - Bypass mid/high: reference straight or divided out.
// - Output enable high stops outputs, bank two runs.
// - Mid bypass, enable high: PLL on, LL banks off.
// - That mode keeps skew except LL banks.
// - Enable low normally; undriven pin reads low.
// - Edge select low falling, high rising alignment.
// - Edge select mid: rising alignment, high drive.
// - VCO range select sets PLL band.
// - Each bank uses own two-digit phase select.
// - Any output may feed back; locks only if it rises within 40 ns after reference edge.
// - Skew moves in discrete time-unit steps.
// - Bank three divides 2/4/1, bank four 2/1.
// - Time unit is period over 32/16/8.
// - Inverted bank four stops high unless edge low.
module multiphase_clock_output_control #(
   parameter int VCO_PERIOD = 64
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clock_in,
   input wire logic loop_return_input,
   input wire logic [1:0] bypass_select,
   input wire logic [1:0] edge_drive_select,
   input wire logic [1:0] vco_range_select,
   input wire logic [15:0] bank_phase_select,
   input wire logic sync_output_enable_n,
   input wire logic sync_output_enable_driven,
   output logic [7:0] bank_clock_out,
   output logic high_drive,
   output logic [1:0] vco_band,
   output logic pll_enabled,
   output logic pll_locked
);

   localparam int TU_MAX = VCO_PERIOD / clock_ctrl_pkg::MF_HIGH;
   localparam int CENTER = clock_ctrl_pkg::WIDE_SKEW_MAX * TU_MAX;
   localparam int DLY = 2 * CENTER + 2;
   localparam int CNT_W = $clog2(VCO_PERIOD);
   localparam int WIN_W = $clog2(clock_ctrl_pkg::LOCK_WIN_CYC + 1);
   localparam int HIT_W = $clog2(clock_ctrl_pkg::LOCK_EDGES + 1);

   if (VCO_PERIOD < clock_ctrl_pkg::MF_LOW || VCO_PERIOD % clock_ctrl_pkg::MF_LOW != 0) begin
      $error("VCO_PERIOD must be a multiple of the largest time unit factor");
   end

   // Comparator pair from the pad: bit 1 above upper threshold, bit 0 above lower.
   function automatic clock_ctrl_pkg::level_t resolve(input logic [1:0] cmp);
      if (cmp[1]) begin
         return clock_ctrl_pkg::LVL_HIGH;
      end else if (cmp[0]) begin
         return clock_ctrl_pkg::LVL_MID;
      end else begin
         return clock_ctrl_pkg::LVL_LOW;
      end
   endfunction

   function automatic int digit(input clock_ctrl_pkg::level_t lvl);
      if (lvl == clock_ctrl_pkg::LVL_HIGH) begin
         return 2;
      end else if (lvl == clock_ctrl_pkg::LVL_MID) begin
         return 1;
      end else begin
         return 0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus.
   logic [8:0] ctrl;
   logic [15:0] phase_reg;
   logic [13:0] status;

   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire hit_ctrl = paddr == clock_ctrl_pkg::ADDR_CTRL;
   wire hit_phase = paddr == clock_ctrl_pkg::ADDR_PHASE;
   wire hit_stat = paddr == clock_ctrl_pkg::ADDR_STATUS;
   wire hit_pstat = paddr == clock_ctrl_pkg::ADDR_PHASE_STATUS;
   wire hit_any = hit_ctrl | hit_phase | hit_stat | hit_pstat;
   wire wr_ctrl = access & pwrite & hit_ctrl;
   wire wr_phase = access & pwrite & hit_phase;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin resolution and selection between pins and software override.
   clock_ctrl_pkg::straps_t pin_straps;
   clock_ctrl_pkg::straps_t sw_straps;
   clock_ctrl_pkg::straps_t straps;
   logic [15:0] pin_phase;
   logic [15:0] phase_codes;

   assign pin_straps.bypass = resolve(bypass_select);
   assign pin_straps.align = resolve(edge_drive_select);
   assign pin_straps.vco = resolve(vco_range_select);
   // A floating enable pin is pulled down, so it reads as running.
   assign pin_straps.oe_n = sync_output_enable_driven & sync_output_enable_n;

   for (genvar p = 0; p < clock_ctrl_pkg::PHASE_W / 2; p++) begin : g_pin
      assign pin_phase[2*p +: 2] = resolve(bank_phase_select[2*p +: 2]);
   end

   assign sw_straps = ctrl[clock_ctrl_pkg::CTRL_STRAP_LSB +: clock_ctrl_pkg::STRAP_W];
   assign straps = ctrl[clock_ctrl_pkg::CTRL_OVR_BIT] ? sw_straps : pin_straps;
   assign phase_codes = ctrl[clock_ctrl_pkg::CTRL_PHASE_OVR_BIT] ? phase_reg : pin_phase;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode.
   wire mid_bypass = straps.bypass == clock_ctrl_pkg::LVL_MID;
   wire full_bypass = straps.bypass == clock_ctrl_pkg::LVL_HIGH;
   // Mid bypass with outputs stopped keeps the loop running.
   wire pll_on = ~full_bypass & ~(mid_bypass & ~straps.oe_n);
   wire edge_low = straps.align == clock_ctrl_pkg::LVL_LOW;
   int tu;

   assign tu = (straps.vco == clock_ctrl_pkg::LVL_HIGH) ? VCO_PERIOD / clock_ctrl_pkg::MF_HIGH :
               (straps.vco == clock_ctrl_pkg::LVL_MID) ? VCO_PERIOD / clock_ctrl_pkg::MF_MID :
               VCO_PERIOD / clock_ctrl_pkg::MF_LOW;

   ////////////////////////////////////////////////////////////////////////////////
   // Reference edge and loop oscillator.
   logic ref_prev;
   logic [CNT_W-1:0] vco_cnt;
   logic [DLY-1:0] hist;
   logic [1:0] div_cnt;

   wire ref_src = edge_low ? ~ref_clock_in : ref_clock_in;
   wire ref_src_prev = edge_low ? ~ref_prev : ref_prev;
   wire ref_edge = ref_src & ~ref_src_prev;
   wire base = vco_cnt < CNT_W'(VCO_PERIOD / 2);
   wire center_tap = hist[CENTER];
   wire center_rise = hist[CENTER] & ~hist[CENTER+1];
   wire div_edge = pll_on ? center_rise : ref_edge;
   // Realigning on every reference edge places the zero-skew tap on that edge.
   // Explicit wrap keeps the period exact when it is not a power of two.
   wire vco_wrap = vco_cnt == CNT_W'(VCO_PERIOD - 1);
   wire [CNT_W-1:0] next_vco_cnt = (pll_on & ref_edge) ? CNT_W'(CENTER % VCO_PERIOD) :
                                   vco_wrap ? '0 : vco_cnt + CNT_W'(1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev <= 1'b0;
         vco_cnt <= '0;
         hist <= '0;
         div_cnt <= 2'h0;
      end else begin
         ref_prev <= ref_clock_in;
         vco_cnt <= next_vco_cnt;
         hist <= {hist[DLY-2:0], base};
         div_cnt <= div_edge ? div_cnt + 2'h1 : div_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lock detector: feedback rising edges must land near reference edges.
   logic fb_prev;
   logic [WIN_W-1:0] win;
   logic [HIT_W-1:0] hits;

   wire fb_rise = loop_return_input & ~fb_prev;
   wire locked_now = hits == HIT_W'(clock_ctrl_pkg::LOCK_EDGES);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_prev <= 1'b0;
         win <= '0;
         hits <= '0;
      end else begin
         fb_prev <= loop_return_input;
         if (ref_edge) begin
            win <= WIN_W'(clock_ctrl_pkg::LOCK_WIN_CYC);
         end else if (win != '0) begin
            win <= win - WIN_W'(1);
         end
         if (!pll_on) begin
            hits <= '0;
         end else if (fb_rise) begin
            if (win == '0 && !ref_edge) begin
               hits <= '0;
            end else if (!locked_now) begin
               hits <= hits + HIT_W'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bank phase, divide and output gating.
   logic [3:0] stopped;

   for (genvar b = 0; b < clock_ctrl_pkg::NUM_BANKS; b++) begin : g_bank
      clock_ctrl_pkg::phase_sel_t sel;
      int code;
      int units;
      int tap;
      logic raw;
      logic stop_req;
      logic stop_level;
      logic en;
      logic out;

      assign sel = phase_codes[4*b +: 4];
      assign code = 3 * digit(sel.hi) + digit(sel.lo);
      // Outer banks take double steps across the same nine codes.
      assign units = (b < 2) ? code - clock_ctrl_pkg::CODE_ZERO :
                     clock_ctrl_pkg::WIDE_SKEW_MULT * (code - clock_ctrl_pkg::CODE_ZERO);
      assign tap = CENTER + units * tu;

      if (b < 2) begin : g_inner
         assign raw = pll_on ? hist[tap] : ref_src;
      end else if (b == 2) begin : g_three
         assign raw = (code == clock_ctrl_pkg::CODE_LL) ? div_cnt[0] :
                      (code == clock_ctrl_pkg::CODE_HH) ? div_cnt[1] :
                      pll_on ? hist[tap] : ref_src;
      end else begin : g_four
         assign raw = (code == clock_ctrl_pkg::CODE_LL) ? div_cnt[0] :
                      (code == clock_ctrl_pkg::CODE_HH) ? ~(pll_on ? center_tap : ref_src) :
                      pll_on ? hist[tap] : ref_src;
      end

      // In mid bypass with enable high the LL code is a per-bank disable; other banks keep skew.
      assign stop_req = straps.oe_n & (mid_bypass ? code == clock_ctrl_pkg::CODE_LL :
                                       b != 1);
      assign stop_level = (b == 3) & (code == clock_ctrl_pkg::CODE_HH) & ~edge_low;
      // Switching only while the clock already sits at the rest level avoids runt pulses.
      wire next_en = (raw == stop_level) ? ~stop_req : en;
      assign out = en ? raw : stop_level;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            en <= 1'b0;
            bank_clock_out[2*b +: 2] <= 2'h0;
         end else begin
            en <= next_en;
            bank_clock_out[2*b +: 2] <= {clock_ctrl_pkg::OUTS_PER_BANK{out}};
         end
      end

      assign stopped[b] = ~en;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status and registered outputs.
   assign status = {stopped, high_drive, pll_locked, pll_enabled, straps};

   wire [31:0] read_mux = hit_ctrl ? {23'h0, ctrl} :
                          hit_phase ? {16'h0, phase_reg} :
                          hit_stat ? {18'h0, status} :
                          hit_pstat ? {16'h0, phase_codes} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= clock_ctrl_pkg::CTRL_RESET;
         phase_reg <= clock_ctrl_pkg::PHASE_RESET;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         high_drive <= 1'b0;
         vco_band <= clock_ctrl_pkg::LVL_LOW;
         pll_enabled <= 1'b0;
         pll_locked <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= pwdata[8:0];
         end
         if (wr_phase) begin
            phase_reg <= pwdata[15:0];
         end
         prdata <= (setup & ~pwrite) ? read_mux : prdata;
         pready <= setup;
         pslverr <= setup & ~hit_any;
         high_drive <= straps.align == clock_ctrl_pkg::LVL_MID;
         vco_band <= straps.vco;
         pll_enabled <= pll_on;
         pll_locked <= pll_on & locked_now;
      end
   end

endmodule

// ### tb/clock_ctrl_props.sv
`timescale 1ns/100ps
module clock_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] bypass_select,
   input wire logic [1:0] edge_drive_select,
   input wire logic [1:0] vco_range_select,
   input wire logic sync_output_enable_n,
   input wire logic sync_output_enable_driven,
   input wire logic [7:0] bank_clock_out,
   input wire logic high_drive,
   input wire logic [1:0] vco_band,
   input wire logic pll_enabled
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A stop may wait a whole divided period for the rest level, so allow 400 cycles.
   logic [8:0] stop_cnt;
   wire stop_cond = sync_output_enable_n && sync_output_enable_driven && bypass_select == 2'h0;
   wire [8:0] next_stop_cnt = (stop_cnt == 9'h1ff) ? stop_cnt : stop_cnt + 9'h001;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_cnt <= 9'h000;
      end else begin
         stop_cnt <= stop_cond ? next_stop_cnt : 9'h000;
      end
   end
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_error: assert property (psel && !penable && paddr > 8'h0c |=> pslverr)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (psel && !penable && paddr == 8'h04 |=> !pslverr)
      else $error("mapped access refused");
   a_edge_mid_drive: assert property (edge_drive_select == 2'h1 [*3] |-> high_drive)
      else $error("high drive missing");
   a_edge_low_drive: assert property
      ((edge_drive_select[1] || edge_drive_select == 2'h0) [*3] |-> !high_drive)
      else $error("high drive unexpected");
   a_bypass_high_off: assert property (bypass_select[1] [*3] |-> !pll_enabled)
      else $error("loop on in bypass");
   a_normal_loop_on: assert property (bypass_select == 2'h0 [*3] |-> pll_enabled)
      else $error("loop off in normal mode");
   a_mid_bypass_on: assert property
      ((bypass_select == 2'h1 && sync_output_enable_n && sync_output_enable_driven) [*3]
      |-> pll_enabled)
      else $error("loop off in mid bypass");
   a_mid_bypass_off: assert property
      ((bypass_select == 2'h1 && !(sync_output_enable_n && sync_output_enable_driven)) [*3]
      |-> !pll_enabled)
      else $error("loop on in mid bypass");
   a_vco_band_follows: assert property ($stable(vco_range_select) [*3] |->
      vco_band == (vco_range_select[1] ? 2'h2 : {1'b0, vco_range_select[0]}))
      else $error("vco band wrong");
   a_stop_banks_low: assert property (stop_cnt == 9'h190 |->
      bank_clock_out[1:0] == 2'h0 && bank_clock_out[5:4] == 2'h0)
      else $error("stopped bank not low");
   a_bank_two_runs: assert property
      (stop_cnt == 9'h190 |-> ##[1:40] $changed(bank_clock_out[2]))
      else $error("bank two halted");
   a_pairs_match: assert property (bank_clock_out[0] == bank_clock_out[1] &&
      bank_clock_out[2] == bank_clock_out[3] && bank_clock_out[7:4] inside {4'h0, 4'h3, 4'hc, 4'hf})
      else $error("bank pair differs");
endmodule
bind multiphase_clock_output_control clock_ctrl_props clock_ctrl_props_i (.pclk, .presetn,
   .psel, .penable, .paddr, .pready, .pslverr, .bypass_select, .edge_drive_select,
   .vco_range_select, .sync_output_enable_n, .sync_output_enable_driven, .bank_clock_out,
   .high_drive, .vco_band, .pll_enabled);

// ### tb/multiphase_clock_output_control_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module multiphase_clock_output_control_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, ref_run = 1'b0, ref_clock_in;
   logic [1:0] bypass_select = 2'h0, edge_drive_select = 2'h2, vco_range_select = 2'h1;
   logic [15:0] bank_phase_select = 16'h5555;
   logic sync_output_enable_n = 1'b0, sync_output_enable_driven = 1'b1;
   logic [7:0] bank_clock_out;
   logic high_drive, pll_enabled, pll_locked;
   logic [1:0] vco_band;
   logic [1:0] lvl [3] = '{2'h0, 2'h1, 2'h2};
   int n_mismatch = 0, n_tests = 0, c;
   ref_clock_source #(.HALF(16)) ref_clock_source_i (.pclk, .run(ref_run), .ref_clock_in);
   multiphase_clock_output_control #(.VCO_PERIOD(32)) multiphase_clock_output_control_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ref_clock_in, .loop_return_input(bank_clock_out[2]), .bypass_select,
      .edge_drive_select, .vco_range_select, .bank_phase_select, .sync_output_enable_n,
      .sync_output_enable_driven, .bank_clock_out, .high_drive, .vco_band, .pll_enabled,
      .pll_locked);
   initial forever #2 pclk = ~pclk;
   ////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rises(input int b, input int n);
      logic p;
      c = 0;
      p = bank_clock_out[b];
      repeat (n) begin
         @(posedge pclk);
         if (bank_clock_out[b] && !p) c++;
         p = bank_clock_out[b];
      end
   endtask
   // Cycles from a rising edge on bit a to the next rising edge on bit b, -1 if none.
   task automatic lag(input int a, input int b);
      logic pa, pb;
      int t;
      c = -1;
      t = -1;
      pa = 1'b1;
      pb = 1'b1;
      repeat (96) begin
         @(posedge pclk);
         if (t >= 0) t++;
         else if (bank_clock_out[a] && !pa) t = 0;
         if (bank_clock_out[b] && !pb && t >= 0 && c < 0) c = t;
         pa = bank_clock_out[a];
         pb = bank_clock_out[b];
      end
   endtask
   function automatic logic near(input int e);
      return c >= e - 1 && c <= e + 1;
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      ref_run <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h04); `CHK(rd, 32'h5555)
      apb(1'b1, 8'h10); `CHK(err, 1'b1)
      apb(1'b1, 8'h04, 32'h9a65);
      apb(1'b1, 8'h00, 32'h100);
      apb(1'b0, 8'h0c); `CHK(rd[15:0], 16'h9a65)
      apb(1'b0, 8'h00); `CHK(rd, 32'h100)
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h04); `CHK(rd, 32'h9a65)
      bank_phase_select <= 16'h60ca;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h0c); `CHK(rd[15:0], 16'h608a)
      for (int i = 0; i < 3; i++) begin
         edge_drive_select <= lvl[i];
         vco_range_select <= lvl[i];
         repeat (4) @(posedge pclk);
         `CHK(high_drive, 1'(i == 1))
         `CHK(vco_band, lvl[i])
      end
      edge_drive_select <= 2'h2;
      vco_range_select <= 2'h1;
      bank_phase_select <= 16'h5555;
      repeat (600) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK(rd[8:7], 2'h3)
      `CHK({pll_enabled, pll_locked}, 2'h3)
      // Bank one at +4 units, bank four at +3 double units, against zero-skew bank two.
      bank_phase_select <= 16'h955a;
      repeat (64) @(posedge pclk);
      lag(2, 0); `CHK(c, 8)
      lag(2, 6); `CHK(c, 12)
      vco_range_select <= 2'h2;
      repeat (64) @(posedge pclk);
      lag(2, 0); `CHK(c, 16)
      vco_range_select <= 2'h1;
      bank_phase_select <= 16'h5555;
      repeat (64) @(posedge pclk);
      sync_output_enable_n <= 1'b1;
      repeat (500) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK(rd[13:10], 4'hd)
      `CHK(bank_clock_out & 8'hf3, 8'h00)
      rises(2, 64); `CHK(near(2), 1'b1)
      // Bank four inverted stops at the opposite level, chosen by edge select.
      bank_phase_select <= 16'ha555;
      repeat (500) @(posedge pclk);
      `CHK(bank_clock_out[7:6], 2'h3)
      edge_drive_select <= 2'h0;
      repeat (500) @(posedge pclk);
      `CHK(bank_clock_out[7:6], 2'h0)
      edge_drive_select <= 2'h2;
      sync_output_enable_driven <= 1'b0;
      repeat (500) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK(rd[13:10], 4'h0)
      sync_output_enable_driven <= 1'b1;
      bypass_select <= 2'h1;
      bank_phase_select <= 16'h5055;
      repeat (500) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK({rd[13:10], rd[7]}, 5'h09)
      apb(1'b0, 8'h0c); `CHK(rd[15:0], 16'h5055)
      sync_output_enable_n <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK(rd[7], 1'b0)
      bypass_select <= 2'h2;
      bank_phase_select <= 16'h0a55;
      repeat (100) @(posedge pclk);
      apb(1'b0, 8'h08); `CHK(rd[7], 1'b0)
      rises(0, 640); `CHK(near(20), 1'b1)
      rises(4, 640); `CHK(near(5), 1'b1)
      rises(6, 640); `CHK(near(10), 1'b1)
      finish_test;
   end
endmodule

// ### tb/ref_clock_source.sv
`timescale 1ns/100ps
module ref_clock_source #(
   parameter int HALF = 16
) (
   input wire logic pclk,
   input wire logic run,
   output logic ref_clock_in
);
   int cnt = 0;
   initial ref_clock_in = 1'b0;
   // The source stands low while stopped, as a gated board oscillator would.
   always @(posedge pclk) begin
      if (!run) begin
         cnt <= 0;
         ref_clock_in <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         ref_clock_in <= ~ref_clock_in;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
